// ==== rtl/ipb_defs.svh ====
// Purpose: Offsets, field positions, reset values and vectors for the controller
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per word
// Notes: Included by the controller and the testbench
`ifndef IPB_DEFS_SVH
`define IPB_DEFS_SVH
// Register offsets
`define IPB_OFF_PRI_A 8'h00
`define IPB_OFF_PRI_B 8'h04
`define IPB_OFF_PRI_C 8'h08
`define IPB_OFF_BRK_CTRL 8'h0C
`define IPB_OFF_BAR_A 8'h10
`define IPB_OFF_BAR_B 8'h14
`define IPB_OFF_BAR_C 8'h18
`define IPB_OFF_SENSE_HI 8'h1C
`define IPB_OFF_SENSE_LO 8'h20
`define IPB_OFF_REQ_EN 8'h24
`define IPB_OFF_REQ_STAT 8'h28
`define IPB_OFF_KEY_MASK_LO 8'h2C
`define IPB_OFF_KEY_MASK_HI 8'h30
`define IPB_OFF_WAKE_MASK 8'h34
`define IPB_OFF_SYS_CTRL 8'h38
`define IPB_OFF_KEY_SENSE 8'h3C
// Reset values
`define IPB_RST_REG8 8'h00
`define IPB_RST_MASK8 8'hFF
// Field positions
`define IPB_BRK_FLAG_BIT 7
`define IPB_BRK_EN_BIT 0
`define IPB_SYS_MODE_LSB 0
`define IPB_SYS_NMI_EDGE_BIT 3
`define IPB_KEY_LEVEL_BIT 0
// Sense codes
`define IPB_SENSE_LOW 2'h0
`define IPB_SENSE_FALL 2'h1
`define IPB_SENSE_RISE 2'h2
`define IPB_SENSE_BOTH 2'h3
// Vectors
`define IPB_VEC_NMI 7'h07
`define IPB_VEC_IRQ_BASE 7'h10
`define IPB_VEC_BREAK 7'h18
`define IPB_VEC_INT_BASE 7'h19
// AXI responses
`define IPB_RESP_OKAY 2'h0
`define IPB_RESP_SLVERR 2'h2
`endif

// ==== rtl/ipb_pkg.sv ====
// Purpose: Types shared by the interrupt controller
// Assumes: Constants come from ipb_defs.svh
// Notes: Only types live here
package ipb_pkg;
  // Control mode field values
  typedef enum logic [1:0] {
    IPB_MODE0 = 2'h0,
    IPB_MODE_RSV1 = 2'h1,
    IPB_MODE1 = 2'h2,
    IPB_MODE_RSV3 = 2'h3
  } ipb_mode_t;
endpackage : ipb_pkg

// ==== rtl/ipb_intc.sv ====
// Purpose: Interrupt priority controller with address break and AXI4-Lite registers
// Assumes: Pin inputs synchronous to clock; request pins, keys and wake-ups active low
// Notes: Vector and level are registered; intAck clears the NMI, break or pin edge flag behind the presented vector
// Function
// R1: NMI outranks everything and is never masked.
// R2: NMI detected on rising or falling edge per a config bit.
// R3: Each request pin detects falling, rising, both edges or low level.
// R4: Pin six merges with the eight lower key inputs into one request.
// R5: Pin seven merges with upper keys and wake-ups into one request.
// R6: Every key and wake-up input has its own software mask.
// R7: Keys and wake-ups use falling edge or low level only.
// R8: Two control modes chosen by a two-bit field in system control.
// R9: Every source has its own vector.
// R10: Priority bit clear means level 0, set means level 1; reset zero.
// R11: Register A maps pins and watchdogs to bits 7..0.
// R12: Registers B and C map timers, serial, two-wire and host units.
// R13: NMI and address break ignore the priority registers.
// R14: Mode plus level gives three priority levels per module.
// R15: Software writes zero to unassigned priority bits.
// R16: Break requested only while match flag and enable are both one.
// R17: Match flag sets on prefetch of break address while enabled.
// R18: Match flag clears on break exception; writes do not touch it.
// R19: Break control bits 6..1 read zero and ignore writes.
// R20: Break control bit 0 is the enable, reset zero.
// R21: Sense 00 low, 01 falling, 10 rising, 11 both edges.
// R22: A request pin reaches the CPU only while its enable is one.
// R23: Break compare uses internal bus; normal mode skips bits 23..16.
// R24: Equal-level pending sources resolve by ascending vector.
`include "ipb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipb_intc (
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External pins
  input wire logic nmiPin,
  input wire logic [7:0] reqPin_n,
  input wire logic [15:0] keyPin_n,
  input wire logic [7:0] wakePin_n,
  // Peripheral requests, levels held by the peripherals
  input wire logic [11:0] periphReq,
  // CPU side
  input wire logic cpuI,
  input wire logic cpuUI,
  input wire logic advancedMode,
  input wire logic fetchValid,
  input wire logic [23:0] fetchAddr,
  input wire logic intAck,
  output logic intReq,
  output logic [6:0] intVector,
  output logic intLevel
);
  // Registers
  logic [7:0] priA, priB, priC, barA, barB, barC;
  logic [7:0] senseHi, senseLo, reqEnable, keyMaskLo, keyMaskHi, wakeMask;
  logic [7:0] sysCtrl, keySense, reqFlag, pinPrev, wakePrev;
  logic breakEn, breakFlag, nmiFlag, nmiPrev;
  logic [15:0] keyPrev;
  // AXI state
  logic awHave, wHave, wLane0;
  logic [7:0] awAddr, wByte, rdAddr;
  // Derived
  logic [7:0] pinEdge, pinLevel, pinActive;
  logic [15:0] keyHit;
  logic [7:0] wakeHit;
  logic keyLevelMode, nmiEdge, breakMatch, breakReq;
  logic [19:0] srcActive, srcLevel;
  ipb_pkg::ipb_mode_t ctrlMode;
  logic next_intReq, next_intLevel;
  logic [6:0] next_intVector;
  logic [31:0] rdValue;
  logic rdMapped, wrMapped;
  assign keyLevelMode = keySense[`IPB_KEY_LEVEL_BIT];
  assign ctrlMode = ipb_pkg::ipb_mode_t'(sysCtrl[`IPB_SYS_MODE_LSB +: 2]); // R8
  // Edge history; NMI starts low so reset never looks like a falling edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nmiPrev <= 1'b0;
      pinPrev <= 8'hFF;
      keyPrev <= 16'hFFFF;
      wakePrev <= 8'hFF;
    end else begin
      nmiPrev <= nmiPin;
      pinPrev <= reqPin_n;
      keyPrev <= keyPin_n;
      wakePrev <= wakePin_n;
    end
  end
  // NMI edge select: 1 rising, 0 falling
  assign nmiEdge = sysCtrl[`IPB_SYS_NMI_EDGE_BIT] ? (nmiPin & ~nmiPrev)
                                                  : (~nmiPin & nmiPrev); // R2
  // NMI pending flag, set wins over acknowledge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nmiFlag <= 1'b0;
    end else if (nmiEdge) begin
      nmiFlag <= 1'b1; // R1
    end else if (intAck && intVector == `IPB_VEC_NMI) begin
      nmiFlag <= 1'b0;
    end
  end
  // Key and wake-up detection: falling edge or low level, per-input mask
  genvar gk;
  generate
    for (gk = 0; gk < 16; gk++) begin : g_key
      assign keyHit[gk] = ~(gk < 8 ? keyMaskLo[gk % 8] : keyMaskHi[gk % 8])
        & (keyLevelMode ? ~keyPin_n[gk] : (~keyPin_n[gk] & keyPrev[gk])); // R6 R7
    end
    for (gk = 0; gk < 8; gk++) begin : g_wake
      assign wakeHit[gk] = ~wakeMask[gk] & (keyLevelMode ? ~wakePin_n[gk]
        : (~wakePin_n[gk] & wakePrev[gk])); // R6 R7
    end
  endgenerate
  // Per-pin sense decode and merged key sources
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_pin
      logic [1:0] sense;
      logic fall, rise, shared;
      assign sense = gp < 4 ? senseLo[2 * (gp % 4) +: 2] : senseHi[2 * (gp % 4) +: 2];
      assign fall = ~reqPin_n[gp] & pinPrev[gp];
      assign rise = reqPin_n[gp] & ~pinPrev[gp];
      if (gp == 6) begin : g_s6
        assign shared = |keyHit[7:0]; // R4
      end else if (gp == 7) begin : g_s7
        assign shared = |keyHit[15:8] | |wakeHit; // R5
      end else begin : g_none
        assign shared = 1'b0;
      end
      always_comb begin
        unique case (sense) // R21
          `IPB_SENSE_LOW: pinEdge[gp] = 1'b0;
          `IPB_SENSE_FALL: pinEdge[gp] = fall;
          `IPB_SENSE_RISE: pinEdge[gp] = rise;
          `IPB_SENSE_BOTH: pinEdge[gp] = fall | rise; // R3
        endcase
      end
      assign pinLevel[gp] = (sense == `IPB_SENSE_LOW && ~reqPin_n[gp])
                          | (keyLevelMode & shared);
      // Edge flag, set wins over acknowledge
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          reqFlag[gp] <= 1'b0;
        end else if (pinEdge[gp] || (!keyLevelMode && shared)) begin
          reqFlag[gp] <= 1'b1;
        end else if (intAck && intVector == `IPB_VEC_IRQ_BASE + 7'(gp)) begin
          reqFlag[gp] <= 1'b0;
        end
      end
      assign pinActive[gp] = (reqFlag[gp] | pinLevel[gp]) & reqEnable[gp]; // R22
    end
  endgenerate
  // Address break compare on the internal bus
  assign breakMatch = fetchValid && breakEn
    && (!advancedMode || fetchAddr[23:16] == barA) // R23
    && fetchAddr[15:8] == barB && fetchAddr[7:1] == barC[7:1];
  // Break match flag: set by prefetch, cleared only by break exception
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      breakFlag <= 1'b0;
    end else if (breakMatch) begin
      breakFlag <= 1'b1; // R17
    end else if (intAck && intVector == `IPB_VEC_BREAK) begin
      breakFlag <= 1'b0; // R18
    end
  end
  assign breakReq = breakFlag & breakEn; // R16
  // Source table: pins 0..7, then watchdogs, timers, serial, two-wire, host
  assign srcActive = {periphReq, pinActive};
  assign srcLevel = {priC[1], priC[2], priC[3], priC[4], priC[6], // R12
                     priB[0], priB[1], priB[2], priB[3], priB[6], // R12
                     priA[0], priA[1], // R11
                     priA[3], priA[3], priA[4], priA[4], priA[5], priA[5],
                     priA[6], priA[7]}; // R10 R11
  // Arbitration: NMI, break, then level 1, then level 0, ascending vector
  always_comb begin
    logic allow1, allow0, found;
    allow1 = !cpuI;
    allow0 = (ctrlMode == ipb_pkg::IPB_MODE1) ? (!cpuI && !cpuUI) : !cpuI; // R14
    found = 1'b0;
    next_intReq = 1'b0;
    next_intVector = 7'h00;
    next_intLevel = 1'b0;
    if (nmiFlag) begin
      found = 1'b1; // R1 R13
      next_intVector = `IPB_VEC_NMI;
      next_intLevel = 1'b1;
    end else if (breakReq && !cpuI) begin
      found = 1'b1; // R13 R16
      next_intVector = `IPB_VEC_BREAK;
      next_intLevel = 1'b1;
    end
    for (int i = 0; i < 20; i++) begin
      if (!found && allow1 && srcActive[i] && srcLevel[i]) begin
        found = 1'b1; // R24
        next_intVector = i < 8 ? `IPB_VEC_IRQ_BASE + 7'(i)
                               : `IPB_VEC_INT_BASE + 7'(i - 8); // R9
        next_intLevel = 1'b1;
      end
    end
    for (int i = 0; i < 20; i++) begin
      if (!found && allow0 && srcActive[i] && !srcLevel[i]) begin
        found = 1'b1; // R24
        next_intVector = i < 8 ? `IPB_VEC_IRQ_BASE + 7'(i)
                               : `IPB_VEC_INT_BASE + 7'(i - 8); // R9
        next_intLevel = 1'b0;
      end
    end
    next_intReq = found;
  end
  // Registered request to the CPU
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intReq <= 1'b0;
      intVector <= 7'h00;
      intLevel <= 1'b0;
    end else begin
      intReq <= next_intReq;
      intVector <= next_intVector;
      intLevel <= next_intLevel;
    end
  end
  // AXI write channel capture
  assign s_axi_awready = !awHave && !s_axi_bvalid;
  assign s_axi_wready = !wHave && !s_axi_bvalid;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 8'h00;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
    end else if (awHave && wHave) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
    end
  end
  // Write decode: the sixteen words 00 to 3C are mapped, the rest answer an error
  assign wrMapped = awAddr[7:6] == 2'b00;
  // Register writes, lane 0 only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      priA <= `IPB_RST_REG8; // R10
      priB <= `IPB_RST_REG8;
      priC <= `IPB_RST_REG8;
      breakEn <= 1'b0; // R20
      barA <= `IPB_RST_REG8;
      barB <= `IPB_RST_REG8;
      barC <= `IPB_RST_REG8;
      senseHi <= `IPB_RST_REG8;
      senseLo <= `IPB_RST_REG8;
      reqEnable <= `IPB_RST_REG8;
      keyMaskLo <= `IPB_RST_MASK8;
      keyMaskHi <= `IPB_RST_MASK8;
      wakeMask <= `IPB_RST_MASK8;
      sysCtrl <= `IPB_RST_REG8;
      keySense <= `IPB_RST_REG8;
    end else if (awHave && wHave && wLane0) begin
      unique case ({awAddr[7:2], 2'b00})
        `IPB_OFF_PRI_A: priA <= wByte; // R15
        `IPB_OFF_PRI_B: priB <= wByte;
        `IPB_OFF_PRI_C: priC <= wByte;
        `IPB_OFF_BRK_CTRL: breakEn <= wByte[`IPB_BRK_EN_BIT]; // R18 R19 R20
        `IPB_OFF_BAR_A: barA <= wByte;
        `IPB_OFF_BAR_B: barB <= wByte;
        `IPB_OFF_BAR_C: barC <= {wByte[7:1], 1'b0};
        `IPB_OFF_SENSE_HI: senseHi <= wByte;
        `IPB_OFF_SENSE_LO: senseLo <= wByte;
        `IPB_OFF_REQ_EN: reqEnable <= wByte;
        `IPB_OFF_KEY_MASK_LO: keyMaskLo <= wByte;
        `IPB_OFF_KEY_MASK_HI: keyMaskHi <= wByte;
        `IPB_OFF_WAKE_MASK: wakeMask <= wByte;
        `IPB_OFF_SYS_CTRL: sysCtrl <= wByte;
        `IPB_OFF_KEY_SENSE: keySense <= {7'h00, wByte[0]};
        default: ;
      endcase
    end
  end
  // Write response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPB_RESP_OKAY;
    end else if (awHave && wHave) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? `IPB_RESP_OKAY : `IPB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Read mux
  always_comb begin
    rdMapped = 1'b1;
    rdValue = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `IPB_OFF_PRI_A: rdValue[7:0] = priA;
      `IPB_OFF_PRI_B: rdValue[7:0] = priB;
      `IPB_OFF_PRI_C: rdValue[7:0] = priC;
      `IPB_OFF_BRK_CTRL: rdValue[7:0] = {breakFlag, 6'h00, breakEn}; // R19
      `IPB_OFF_BAR_A: rdValue[7:0] = barA;
      `IPB_OFF_BAR_B: rdValue[7:0] = barB;
      `IPB_OFF_BAR_C: rdValue[7:0] = barC;
      `IPB_OFF_SENSE_HI: rdValue[7:0] = senseHi;
      `IPB_OFF_SENSE_LO: rdValue[7:0] = senseLo;
      `IPB_OFF_REQ_EN: rdValue[7:0] = reqEnable;
      `IPB_OFF_REQ_STAT: rdValue[7:0] = reqFlag | pinLevel;
      `IPB_OFF_KEY_MASK_LO: rdValue[7:0] = keyMaskLo;
      `IPB_OFF_KEY_MASK_HI: rdValue[7:0] = keyMaskHi;
      `IPB_OFF_WAKE_MASK: rdValue[7:0] = wakeMask;
      `IPB_OFF_SYS_CTRL: rdValue[7:0] = sysCtrl;
      `IPB_OFF_KEY_SENSE: rdValue[7:0] = keySense;
      default: rdMapped = 1'b0;
    endcase
  end
  // Read channel, one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IPB_RESP_OKAY;
      rdAddr <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdValue;
      s_axi_rresp <= rdMapped ? `IPB_RESP_OKAY : `IPB_RESP_SLVERR;
      rdAddr <= {s_axi_araddr[7:2], 2'b00};
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_fall0;
    senseLo[1:0] == `IPB_SENSE_FALL && reqPin_n[0] ##1 !reqPin_n[0];
  endsequence
  a_nmi_wins: assert property (nmiFlag |=> intReq && intVector == `IPB_VEC_NMI) // R1
    else $error("NMI not presented first");
  a_nmi_edge: assert property (sysCtrl[3] && !nmiPrev && nmiPin |=> nmiFlag) // R2
    else $error("NMI rising edge missed");
  a_fall_sense: assert property (s_fall0 |=> reqFlag[0]) // R3
    else $error("Falling edge on pin 0 not latched");
  a_level_sense: assert property (senseLo[7:6] == `IPB_SENSE_LOW && !reqPin_n[3]
    && reqEnable[3] && !cpuI && !cpuUI |=> intReq) // R21
    else $error("Low level on pin 3 not requested");
  a_enable_gate: assert property (intReq && intVector == `IPB_VEC_IRQ_BASE
    |-> $past(reqEnable[0])) // R22
    else $error("Disabled pin 0 reached CPU");
  a_break_set: assert property (breakMatch |=> breakFlag ##0 $past(breakEn)) // R17
    else $error("Break match flag not set");
  a_break_gate: assert property (intReq && intVector == `IPB_VEC_BREAK
    |-> $past(breakFlag && breakEn)) // R16
    else $error("Break raised without flag and enable");
  a_break_clear: assert property (intAck && intVector == `IPB_VEC_BREAK && !breakMatch
    |=> !breakFlag) // R18
    else $error("Break flag not cleared by exception");
  a_bcr_zeros: assert property (s_axi_rvalid && rdAddr == `IPB_OFF_BRK_CTRL
    |-> s_axi_rdata[6:1] == 6'h00) // R19
    else $error("Break control reserved bits nonzero");
  a_cpu_mask: assert property (cpuI && !nmiFlag |=> !intReq) // R8 R14
    else $error("Masked request reached CPU");
endmodule : ipb_intc
`default_nettype wire

// ==== tb/ipb_cpu_model.sv ====
// Purpose: CPU core partner that takes presented interrupt vectors
// Assumes: One intAck pulse retires the vector presented with it
// Notes: ackDelay sets how slowly a pending request is answered
`timescale 1ns/1ps
`default_nettype none
module ipb_cpu_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic intReq,
  input wire logic [6:0] intVector,
  input wire logic ackOn,
  input wire logic [2:0] ackDelay,
  output logic intAck,
  output logic [6:0] takenVector,
  output logic [7:0] takenCount
);
  logic [2:0] holdOff;
  logic [2:0] lag;
  // Answer after ackDelay cycles, then back off while the request retires
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intAck <= 1'b0;
      takenVector <= 7'h00;
      takenCount <= 8'h00;
      holdOff <= 3'h0;
      lag <= 3'h0;
    end else begin
      intAck <= 1'b0;
      if (intAck) begin
        takenVector <= intVector; // Vector retired by the standing pulse
      end
      if (holdOff != 3'h0) begin
        holdOff <= holdOff - 3'h1;
      end else if (ackOn && intReq && lag >= ackDelay) begin
        intAck <= 1'b1;
        takenCount <= takenCount + 8'h01;
        holdOff <= 3'h5; // Covers the two cycles the request needs to drop
        lag <= 3'h0;
      end else if (ackOn && intReq) begin
        lag <= lag + 3'h1;
      end
    end
  end
endmodule : ipb_cpu_model
`default_nettype wire

// ==== tb/ipb_intc_tb.sv ====
// Purpose: Self-checking bench for the interrupt priority controller
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes: Request, key and wake-up pins idle high, NMI idles low; a CPU model retires presented vectors
`include "ipb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipb_intc_tb;
  logic clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmiPin;
  logic cpuI, cpuUI, advancedMode, fetchValid, ackOn, intAck, intReq, intLevel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] ackDelay;
  logic [3:0] s_axi_wstrb;
  logic [6:0] intVector, takenVector;
  logic [7:0] s_axi_awaddr, s_axi_araddr, reqPin_n, wakePin_n, takenCount;
  logic [11:0] periphReq;
  logic [15:0] keyPin_n;
  logic [23:0] fetchAddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int errors, compares;
  ipb_intc dut (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .nmiPin, .reqPin_n, .keyPin_n, .wakePin_n, .periphReq, .cpuI, .cpuUI, .advancedMode,
    .fetchValid, .fetchAddr, .intAck, .intReq, .intVector, .intLevel
  );
  ipb_cpu_model cpu (
    .clock, .rst, .intReq, .intVector, .ackOn, .ackDelay, .intAck, .takenVector, .takenCount
  );
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Request line and vector, vector ignored when idle
  task automatic irqChk(input string what, input logic req, input logic [6:0] vec);
    check(what, {req, vec}, {intReq, req ? intVector : vec});
  endtask : irqChk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Verdict
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // Bus write, address and data released as each is taken
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : regWrite
  // Bus read
  task automatic regRead(input logic [7:0] a, output logic [7:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : regRead
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    regWrite(a, d, r);
  endtask : wr
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    regRead(a, d, r);
    check(what, exp, d);
  endtask : rdChk
  // Reset values, reserved bits, unmapped address
  task automatic testRegs();
    logic [7:0] d;
    logic [1:0] r;
    rdChk("pri a reset", `IPB_OFF_PRI_A, 8'h00);
    rdChk("pri b reset", `IPB_OFF_PRI_B, 8'h00);
    rdChk("pri c reset", `IPB_OFF_PRI_C, 8'h00);
    rdChk("brk reset", `IPB_OFF_BRK_CTRL, 8'h00);
    rdChk("wake mask reset", `IPB_OFF_WAKE_MASK, 8'hFF);
    wr(`IPB_OFF_BRK_CTRL, 8'hFE);
    rdChk("brk reserved", `IPB_OFF_BRK_CTRL, 8'h00);
    wr(`IPB_OFF_PRI_A, 8'hFB);
    rdChk("pri a rw", `IPB_OFF_PRI_A, 8'hFB);
    wr(`IPB_OFF_PRI_A, 8'h00);
    regWrite(8'h40, 8'h55, r);
    check("unmapped write", {6'h0, `IPB_RESP_SLVERR}, {6'h0, r});
    regRead(8'h40, d, r);
    check("unmapped read", {6'h0, `IPB_RESP_SLVERR}, {6'h0, r});
    $display("regs done");
  endtask : testRegs
  // Sense codes per pin and the enable gate
  task automatic testPins();
    logic [7:0] base;
    wr(`IPB_OFF_SENSE_LO, 8'h39);
    wr(`IPB_OFF_REQ_EN, 8'h0F);
    ackDelay <= 3'h2;
    ackOn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      base = takenCount;
      reqPin_n[i] <= 1'b0;
      tick(12);
      reqPin_n[i] <= 1'b1;
      tick(12);
      check("edge count", base + ((i == 2) ? 8'h02 : 8'h01), takenCount);
      check("edge vector", 8'(`IPB_VEC_IRQ_BASE + i), {1'b0, takenVector});
    end
    ackOn <= 1'b0;
    reqPin_n[3] <= 1'b0;
    tick(4);
    irqChk("low level", 1'b1, 7'h13);
    wr(`IPB_OFF_REQ_EN, 8'h07);
    tick(3);
    irqChk("pin disabled", 1'b0, 7'h00);
    reqPin_n[3] <= 1'b1;
    wr(`IPB_OFF_REQ_EN, 8'h00);
    $display("pins done");
  endtask : testPins
  // Levels, fixed order, control mode and the nonmaskable input
  task automatic testPriority();
    periphReq <= 12'h801;
    tick(3);
    irqChk("level0 order", 1'b1, 7'h19);
    check("level0 out", 8'h00, {7'h0, intLevel});
    wr(`IPB_OFF_PRI_C, 8'h02);
    tick(3);
    irqChk("level1 first", 1'b1, 7'h24);
    check("level out", 8'h01, {7'h0, intLevel});
    wr(`IPB_OFF_PRI_A, 8'h02);
    tick(3);
    irqChk("level1 order", 1'b1, 7'h19);
    wr(`IPB_OFF_PRI_A, 8'h00);
    wr(`IPB_OFF_SYS_CTRL, 8'h0A);
    cpuUI <= 1'b1;
    tick(3);
    irqChk("mode1 level1", 1'b1, 7'h24);
    wr(`IPB_OFF_PRI_C, 8'h00);
    tick(3);
    irqChk("mode1 level0", 1'b0, 7'h00);
    cpuI <= 1'b1;
    nmiPin <= 1'b1;
    tick(3);
    irqChk("nmi unmasked", 1'b1, `IPB_VEC_NMI);
    periphReq <= 12'h000;
    ackOn <= 1'b1;
    tick(10);
    check("nmi taken", {1'b0, `IPB_VEC_NMI}, {1'b0, takenVector});
    ackOn <= 1'b0;
    nmiPin <= 1'b0;
    tick(4);
    irqChk("nmi fall ignored", 1'b0, 7'h00);
    {cpuI, cpuUI} <= 2'h0;
    wr(`IPB_OFF_SYS_CTRL, 8'h00);
    $display("priority done");
  endtask : testPriority
  task automatic fetch(input logic [23:0] a);
    fetchAddr <= a;
    fetchValid <= 1'b1;
    tick(1);
    fetchValid <= 1'b0;
    tick(3);
  endtask : fetch
  // Address break match, flag life and compare width
  task automatic testBreak();
    wr(`IPB_OFF_BAR_A, 8'h12);
    wr(`IPB_OFF_BAR_B, 8'h34);
    wr(`IPB_OFF_BAR_C, 8'h56);
    fetch(24'h123456);
    rdChk("no match off", `IPB_OFF_BRK_CTRL, 8'h00);
    wr(`IPB_OFF_BRK_CTRL, 8'h01);
    advancedMode <= 1'b1;
    fetch(24'hAB3456);
    rdChk("wide compare", `IPB_OFF_BRK_CTRL, 8'h01);
    advancedMode <= 1'b0;
    fetch(24'hAB3456);
    rdChk("match flag", `IPB_OFF_BRK_CTRL, 8'h81);
    irqChk("break req", 1'b1, `IPB_VEC_BREAK);
    wr(`IPB_OFF_BRK_CTRL, 8'h00);
    tick(3);
    irqChk("break off", 1'b0, 7'h00);
    rdChk("flag kept", `IPB_OFF_BRK_CTRL, 8'h80);
    wr(`IPB_OFF_BRK_CTRL, 8'h01);
    ackOn <= 1'b1;
    tick(10);
    check("break taken", {1'b0, `IPB_VEC_BREAK}, {1'b0, takenVector});
    rdChk("flag cleared", `IPB_OFF_BRK_CTRL, 8'h01);
    ackOn <= 1'b0;
    wr(`IPB_OFF_BRK_CTRL, 8'h00);
    $display("break done");
  endtask : testBreak
  task automatic keyEvent(input logic [15:0] k, input logic [7:0] w);
    keyPin_n <= ~k;
    wakePin_n <= ~w;
    tick(3);
    keyPin_n <= 16'hFFFF;
    wakePin_n <= 8'hFF;
    tick(12);
  endtask : keyEvent
  // Shared key and wake-up requests with masks and sense
  task automatic testKeys();
    logic [7:0] base;
    wr(`IPB_OFF_KEY_MASK_LO, 8'hFE);
    wr(`IPB_OFF_KEY_MASK_HI, 8'hFE);
    wr(`IPB_OFF_WAKE_MASK, 8'hFE);
    wr(`IPB_OFF_REQ_EN, 8'hC0);
    ackOn <= 1'b1;
    base = takenCount;
    keyEvent(16'h0002, 8'h00);
    check("masked key", base, takenCount);
    keyEvent(16'h0001, 8'h00);
    check("low key", 8'h16, {1'b0, takenVector});
    keyEvent(16'h0100, 8'h00);
    check("high key", 8'h17, {1'b0, takenVector});
    keyEvent(16'h0000, 8'h01);
    check("wake", 8'h17, {1'b0, takenVector});
    check("event count", base + 8'h03, takenCount);
    ackOn <= 1'b0;
    wr(`IPB_OFF_KEY_SENSE, 8'h01);
    keyPin_n <= 16'hFFFE;
    tick(4);
    irqChk("key level", 1'b1, 7'h16);
    keyPin_n <= 16'hFFFF;
    tick(4);
    irqChk("key released", 1'b0, 7'h00);
    $display("keys done");
  endtask : testKeys
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog
  initial begin
    repeat (6000) @(posedge clock);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {nmiPin, cpuI, cpuUI, advancedMode, fetchValid, ackOn} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
    {reqPin_n, wakePin_n, keyPin_n} = 32'hFFFFFFFF;
    {periphReq, fetchAddr, ackDelay} = 39'h0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    testRegs();
    testPins();
    testPriority();
    testBreak();
    testKeys();
    conclude();
  end
endmodule : ipb_intc_tb
`default_nettype wire
